//--- shared/ptr_pkg.sv
// Package with the constants shared by the PCI target memory read claim block.
package ptr_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int DW_W = 32;
	localparam int CMD_W = 4;
	localparam int BE_W = 8;
	localparam int NUM_BAR = 6;
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
	localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
	localparam logic [31:0] BAR_BASE_RST = 32'h1000_0000;
	localparam logic [31:0] BAR_MASK_RST = 32'hffff_f000;
	// Extra wait cycles between driver turn-on and the claim; zero keeps the claim three cycles after the address.
	localparam logic [1:0] DECODE_CYCLES = 2'h0;
	localparam int BUF_DEPTH = 2;
	typedef enum logic [5:0] {
		PTR_IDLE = 6'b000001,
		PTR_DECODE = 6'b000010,
		PTR_WAIT = 6'b000100,
		PTR_CLAIM = 6'b001000,
		PTR_DATA = 6'b010000,
		PTR_DONE = 6'b100000
	} ptr_state_t;
endpackage

//--- src/ptr_buf.sv
// Two-entry skid buffer between the local read data and the PCI data phases.
`timescale 1ns/10ps
module ptr_buf #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 2
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic flush,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [$clog2(DEPTH)-1:0] wp_r;
	logic [$clog2(DEPTH)-1:0] rp_r;
	logic [$clog2(DEPTH):0] cnt_r;
	logic push;
	logic pop;

	assign in_ready = (cnt_r != DEPTH[$clog2(DEPTH):0]);
	assign out_valid = (cnt_r != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge mclk) begin
		if (clk_en && push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	// Read data leave from a register so the PCI data lines switch cleanly.
	always_ff @(posedge mclk) begin
		if (clk_en) begin
			out_data <= mem_r[pop ? rp_r + 1'b1 : rp_r];
			if (push && (cnt_r == '0 || (pop && cnt_r == {{$clog2(DEPTH){1'b0}}, 1'b1}))) begin
				out_data <= in_data;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || (clk_en && flush)) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else if (clk_en) begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r <= cnt_r + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
		end
	end
endmodule

//--- src/ptr_target.sv
// Target end of PCI memory reads: address decode, driver enable, claim and data phases.
// Operation
// R1: Master asserts framen with address on ad[31:0] and command on cben[3:0].
// R2: Master asserts req64n with framen to request a 64-bit transfer.
// R3: Cycle after the address phase is turn-around; nobody drives ad.
// R4: Master presents first byte enables on cben during turn-around.
// R5: On a BAR hit, enable ad, devseln, trdyn, stopn, par, plus par64, ack64n.
// R6: After enabling drivers, assert devseln, with ack64n for 64-bit reads.
// R7: After claiming, run one or more data phases, single or burst.
// R8: Support single-cycle, burst and mismatched-width memory reads.
// R9: Accept 32-bit reads without req64n from a 64-bit target.
// R10: Slow decode: devseln and ack64n asserted three cycles after valid address.
// R11: Mismatched width: fetch 64-bit local words, return one doubleword per phase.
// R12: Memory read line and read multiple behave as plain memory read.
// R13: On no BAR hit, keep drivers off and never assert devseln or ack64n.
`timescale 1ns/10ps
module ptr_target #(
	parameter logic [31:0] BAR_BASE = ptr_pkg::BAR_BASE_RST,
	parameter logic [31:0] BAR_MASK = ptr_pkg::BAR_MASK_RST
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic framen,
	input wire logic req64n,
	input wire logic irdyn,
	input wire logic [ptr_pkg::DATA_W-1:0] ad_in,
	input wire logic [ptr_pkg::BE_W-1:0] cben_in,
	output logic [ptr_pkg::DATA_W-1:0] ad_out,
	output logic ad_lo_oe,
	output logic ad_hi_oe,
	output logic devseln_out,
	output logic trdyn_out,
	output logic stopn_out,
	output logic ack64n_out,
	output logic ctl_oe,
	output logic ack64_oe,
	output logic par_out,
	output logic par_oe,
	output logic par64_out,
	output logic par64_oe,
	output logic [ptr_pkg::ADDR_W-1:0] lcl_addr,
	output logic lcl_req,
	output logic lcl_is64,
	input wire logic [ptr_pkg::DATA_W-1:0] lcl_data,
	input wire logic lcl_valid,
	output logic lcl_ready,
	output logic [ptr_pkg::BE_W-1:0] lcl_be,
	output logic busy
);
	import ptr_pkg::*;

	ptr_state_t state_r;
	ptr_state_t state_nxt;
	logic [ADDR_W-1:0] addr_r;
	logic [CMD_W-1:0] cmd_r;
	logic is64_r;
	logic [1:0] dec_cnt_r;
	logic hi_dw_r;
	logic hit;
	logic is_read;
	logic [DATA_W-1:0] buf_data;
	logic buf_valid;
	logic buf_ready;
	logic xfer;
	logic [DATA_W-1:0] ad_nxt;

	// Line and multiple variants fall into the same read path.
	assign is_read = (cmd_r == CMD_MEM_READ) || (cmd_r == CMD_MEM_READ_LINE) || // R12
		(cmd_r == CMD_MEM_READ_MULT);
	assign hit = is_read && ((addr_r & BAR_MASK) == (BAR_BASE & BAR_MASK)); // R13

	// The master's initial byte enables are sampled at turn-around and passed on.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lcl_be <= '0;
		end else if (clk_en && state_r == PTR_DECODE) begin
			lcl_be <= ~cben_in; // R4
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			addr_r <= '0;
			cmd_r <= '0;
			is64_r <= 1'b0;
		end else if (clk_en && state_r == PTR_IDLE && !framen) begin
			addr_r <= ad_in[ADDR_W-1:0]; // R1
			cmd_r <= cben_in[CMD_W-1:0]; // R1
			is64_r <= !req64n; // R2 R9
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PTR_IDLE: begin
				if (!framen) begin
					state_nxt = PTR_DECODE;
				end
			end
			PTR_DECODE: begin
				// Turn-around: ad stays undriven here whatever the decode says.
				state_nxt = hit ? PTR_WAIT : PTR_DONE; // R3 R13
			end
			PTR_WAIT: begin
				if (dec_cnt_r == DECODE_CYCLES) begin
					state_nxt = PTR_CLAIM; // R10
				end
			end
			PTR_CLAIM: begin
				state_nxt = PTR_DATA; // R6
			end
			PTR_DATA: begin
				// The master decides the length, so a narrow read may end after a low doubleword.
				if (xfer && framen) begin
					state_nxt = PTR_IDLE; // R7 R8
				end
			end
			PTR_DONE: begin
				if (framen && irdyn) begin
					state_nxt = PTR_IDLE;
				end
			end
			default: begin
				state_nxt = PTR_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r <= PTR_IDLE;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dec_cnt_r <= '0;
		end else if (clk_en) begin
			dec_cnt_r <= (state_r == PTR_WAIT) ? dec_cnt_r + 2'h1 : 2'h0;
		end
	end

	// A data phase completes when the master is ready and the target has data.
	assign xfer = (state_r == PTR_DATA) && !irdyn && !trdyn_out;

	// The low doubleword goes out first; the high one follows on a 32-bit read.
	always_ff @(posedge mclk) begin
		if (sys_rst || (clk_en && state_r != PTR_DATA)) begin
			hi_dw_r <= 1'b0;
		end else if (clk_en && xfer && !is64_r) begin
			hi_dw_r <= !hi_dw_r; // R11
		end
	end

	assign lcl_req = (state_r == PTR_CLAIM) || (state_r == PTR_DATA);
	assign lcl_addr = addr_r;
	assign lcl_is64 = is64_r;
	assign busy = (state_r != PTR_IDLE);
	// A 64-bit word leaves the buffer only after both halves went out on a narrow bus.
	assign buf_ready = xfer && (is64_r || hi_dw_r); // R11

	ptr_buf #(
		.WIDTH(DATA_W),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.flush(state_r == PTR_IDLE),
		.in_data(lcl_data),
		.in_valid(lcl_valid && lcl_req),
		.in_ready(lcl_ready),
		.out_data(buf_data),
		.out_valid(buf_valid),
		.out_ready(buf_ready)
	);

	always_comb begin
		ad_nxt = buf_data;
		if (!is64_r && hi_dw_r) begin
			ad_nxt = {buf_data[DATA_W-1:DW_W], buf_data[DATA_W-1:DW_W]}; // R11
		end
	end

	// Data lines are combinational from the registered buffer head; parity lags one cycle.
	assign ad_out = ad_nxt;
	assign trdyn_out = !(state_r == PTR_DATA && buf_valid); // R7
	assign stopn_out = 1'b1;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			devseln_out <= 1'b1;
			ack64n_out <= 1'b1;
			ctl_oe <= 1'b0;
			ack64_oe <= 1'b0;
			ad_lo_oe <= 1'b0;
			ad_hi_oe <= 1'b0;
			par_oe <= 1'b0;
			par64_oe <= 1'b0;
			par_out <= 1'b0;
			par64_out <= 1'b0;
		end else if (clk_en) begin
			// Drivers on from the cycle after turn-around until the transaction ends.
			ctl_oe <= (state_nxt == PTR_WAIT) || (state_nxt == PTR_CLAIM) || (state_nxt == PTR_DATA); // R5 R13
			ack64_oe <= is64_r && ((state_nxt == PTR_WAIT) || (state_nxt == PTR_CLAIM) ||
				(state_nxt == PTR_DATA)); // R5
			ad_lo_oe <= (state_nxt == PTR_WAIT) || (state_nxt == PTR_CLAIM) || (state_nxt == PTR_DATA); // R5
			ad_hi_oe <= is64_r && ((state_nxt == PTR_WAIT) || (state_nxt == PTR_CLAIM) ||
				(state_nxt == PTR_DATA)); // R5
			par_oe <= ad_lo_oe; // R5
			par64_oe <= ad_hi_oe; // R5
			devseln_out <= !((state_nxt == PTR_CLAIM) || (state_nxt == PTR_DATA)); // R6 R10
			ack64n_out <= !(is64_r && ((state_nxt == PTR_CLAIM) || (state_nxt == PTR_DATA))); // R6
			par_out <= ^{ad_out[DW_W-1:0], ~lcl_be[3:0]};
			par64_out <= ^{ad_out[DATA_W-1:DW_W], ~lcl_be[7:4]};
		end
	end
endmodule

//--- testbench/ptr_master.sv
// Behavioural PCI master issuing memory reads.
`timescale 1ns/10ps
module ptr_master (
	input wire logic mclk,
	output logic framen = 1'b1,
	output logic req64n = 1'b1,
	output logic irdyn = 1'b1,
	output logic [ptr_pkg::DATA_W-1:0] ad_m = 64'h0,
	output logic [ptr_pkg::BE_W-1:0] cben_in = 8'h0,
	input wire logic trdyn_out,
	input wire logic [ptr_pkg::DATA_W-1:0] ad_out
);
	import ptr_pkg::*;
	logic [63:0] got[$];
	task automatic rd(input logic [31:0] a, input logic [3:0] c, input logic w, input int n, input logic [7:0] be,
		input logic slow);
		int k;
		int t;
		k = 0;
		t = 0;
		got.delete();
		@(negedge mclk);
		framen = 1'b0;
		req64n = !w;
		ad_m = {~a, a};
		cben_in = {4'h0, c};
		while ((n == 0 ? t < 10 : k < n) && t < 40) begin
			@(negedge mclk);
			// Released lines flip each cycle so a stale value cannot pass for data.
			ad_m = ~ad_m;
			cben_in = be;
			framen = n - k < 2;
			req64n = !w || n - k < 2;
			irdyn = slow && n - k > 1 && t[0];
			#1;
			if (!irdyn && !trdyn_out) begin
				got.push_back(w ? ad_out : {32'h0, ad_out[31:0]});
				k++;
			end
			t++;
		end
		@(negedge mclk);
		framen = 1'b1;
		irdyn = 1'b1;
		req64n = 1'b1;
		@(negedge mclk);
	endtask
endmodule

//--- testbench/ptr_target_chk.sv
// Checker for claim timing and driver enables of the target.
`timescale 1ns/10ps
module ptr_target_chk #(
	parameter logic [31:0] BAR_BASE = 32'h1000_0000,
	parameter logic [31:0] BAR_MASK = 32'hffff_f000
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic framen,
	input wire logic req64n,
	input wire logic [ptr_pkg::DATA_W-1:0] ad_in,
	input wire logic [ptr_pkg::BE_W-1:0] cben_in,
	input wire logic busy,
	input wire logic ctl_oe,
	input wire logic ad_lo_oe,
	input wire logic ad_hi_oe,
	input wire logic par64_oe,
	input wire logic devseln_out,
	input wire logic ack64n_out,
	input wire logic ack64_oe,
	input wire logic trdyn_out,
	input wire logic par_oe
);
	import ptr_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic st, hit;
	assign st = !framen && !busy;
	assign hit = cben_in[3:0] inside {CMD_MEM_READ, CMD_MEM_READ_MULT, CMD_MEM_READ_LINE} &&
		(ad_in[31:0] & BAR_MASK) == (BAR_BASE & BAR_MASK);
	a_hit_drivers_on: assert property (st && hit |-> ##2 ctl_oe && ad_lo_oe)
		else $error("drivers late");
	a_miss_stays_quiet: assert property (st && !hit |-> ##1 (!ctl_oe && devseln_out && ack64n_out)[*8])
		else $error("miss claimed");
	a_slow_decode: assert property (st && hit |-> ##1 devseln_out[*2] ##1 !devseln_out)
		else $error("claim timing");
	a_ack64_claim: assert property (st && hit && !req64n |-> ##3 !ack64n_out)
		else $error("no ack64");
	a_wide_drivers: assert property (st && hit && !req64n |-> ##2 ad_hi_oe && ack64_oe)
		else $error("wide drivers late");
	a_par64_follows: assert property ($rose(ad_hi_oe) |=> par64_oe)
		else $error("par64 oe late");
	a_ack64_narrow: assert property (st && hit && req64n |-> ##1 ack64n_out[*8])
		else $error("ack64 on 32-bit");
	a_ack64_pair: assert property (!ack64n_out |-> !devseln_out && ack64_oe)
		else $error("ack64 alone");
	a_claim_after_oe: assert property (!devseln_out |-> $past(ctl_oe))
		else $error("claim before oe");
	a_data_claimed: assert property (!trdyn_out |-> !devseln_out && ctl_oe && ad_lo_oe)
		else $error("trdy unclaimed");
	a_par_follows: assert property ($rose(ad_lo_oe) |=> par_oe)
		else $error("par oe late");
endmodule

//--- testbench/test_ptr_target.sv
// Self-checking bench for the target read claim block.
`timescale 1ns/10ps
module test_ptr_target;
	import ptr_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic lcl_valid = 1'b0;
	logic took = 1'b0;
	logic framen, req64n, irdyn, ad_lo_oe, ad_hi_oe, devseln_out, trdyn_out, stopn_out, ack64n_out, ctl_oe;
	logic ack64_oe, par_out, par_oe, par64_out, par64_oe, lcl_req, lcl_is64, lcl_ready, busy;
	logic [63:0] ad_m, ad_out, ad_in;
	logic [63:0] lcl_data = 64'h0;
	logic [7:0] cben_in, lcl_be;
	logic [7:0] s = 8'h1a;
	logic [7:0] r = 8'h1a;
	logic [31:0] lcl_addr;
	int mismatches = 0, n_compared = 0, cyc = 0, widx = 0;
	always #5 mclk = ~mclk;
	assign ad_in = {ad_hi_oe ? ad_out[63:32] : ad_m[63:32], ad_lo_oe ? ad_out[31:0] : ad_m[31:0]};
	ptr_master m (.*);
	ptr_target uut (.clk_en(1'b1), .*);
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic [63:0] pat(input int k);
		return {32'(k) ^ 32'h5a5a_5a5a, 32'(k) + 32'h0000_0100};
	endfunction
	function automatic logic [63:0] expw(input int j, input logic w);
		logic [63:0] v;
		v = pat(w ? j : j / 2);
		return w ? v : {32'h0, j % 2 ? v[63:32] : v[31:0]};
	endfunction
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Local side stalls at random and holds each word until it is taken.
	always @(posedge mclk) took <= lcl_valid && lcl_ready;
	always @(negedge mclk) begin
		r = lfsr(r);
		if (took) widx++;
		lcl_valid <= lcl_req && (lcl_valid && !took || r[0]);
		lcl_data <= pat(widx);
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		logic [31:0] a;
		logic [3:0] c;
		logic w;
		int n;
		repeat (4) @(negedge mclk);
		sys_rst = 1'b0;
		for (int i = 0; i < 24; i++) begin
			s = lfsr(s);
			a = BAR_BASE_RST | {20'h0, s, 4'h0};
			c = (i % 3 == 0) ? CMD_MEM_READ : (i % 3 == 1) ? CMD_MEM_READ_MULT : CMD_MEM_READ_LINE;
			w = i < 3 || s[2];
			n = s[1:0] + 1;
			if (i == 3 || s[7:6] == 2'h3) a[31] = 1'b1;
			if (i == 4) c = 4'h7;
			if (a[31] || i == 4) n = 0;
			m.rd(a, c, w, n, s, s[3] && i > 2);
			#2;
			chk(m.got.size(), n);
			for (int j = 0; j < n; j++) chk(m.got[j], expw(j, w));
			if (n > 0) chk({lcl_addr, lcl_is64, lcl_be[3:0]}, {a, w, ~s[3:0]});
			widx = 0;
			$display("test %0d done", i);
		end
		give_verdict();
	end
endmodule
bind ptr_target ptr_target_chk #(.BAR_BASE(BAR_BASE), .BAR_MASK(BAR_MASK)) chk (.*);
